// ### hw/pss_pkg.sv
package pss_pkg;

  // Widths and counts
  localparam int PSS_ADDR_W = 8;
  localparam int PSS_DATA_W = 32;
  localparam int PSS_CODE_W = 4;
  localparam int PSS_PIN_CNT = 6;
  localparam int PSS_SLOTS = 16;
  localparam int PSS_NAME_W = 32;
  localparam int PSS_FREQ_W = 24;
  localparam int PSS_MODE_W = 5;

  // Register offsets
  localparam logic [7:0] PSS_A_CMD = 8'h00;
  localparam logic [7:0] PSS_A_ARG = 8'h04;
  localparam logic [7:0] PSS_A_NAME = 8'h08;
  localparam logic [7:0] PSS_A_STATUS = 8'h0c;
  localparam logic [7:0] PSS_A_CH1 = 8'h10;
  localparam logic [7:0] PSS_A_CH2 = 8'h14;
  localparam logic [7:0] PSS_A_RPT_CFG = 8'h18;
  localparam logic [7:0] PSS_A_RPT_NAME = 8'h1c;
  localparam logic [7:0] PSS_A_PINMAP = 8'h20;

  // Command codes
  localparam logic [3:0] PSS_CMD_SAVE = 4'h1;
  localparam logic [3:0] PSS_CMD_LIST = 4'h2;
  localparam logic [3:0] PSS_CMD_PINMAP = 4'h3;
  localparam logic [3:0] PSS_CMD_CHAN = 4'h4;
  localparam logic [3:0] PSS_CMD_MODE = 4'h5;
  localparam logic [3:0] PSS_CMD_FEC = 4'h6;
  localparam logic [3:0] PSS_CMD_FREQ = 4'h7;
  localparam logic [3:0] PSS_CMD_FLAGS = 4'h8;

  // Field positions in the command word
  localparam int PSS_F_OP = 0;
  localparam int PSS_F_HASARG = 4;

  // Values with documented meaning
  localparam logic [1:0] PSS_CH_BOTH = 2'h3;
  localparam logic [4:0] PSS_MODE_SOQPSK = 5'h01;
  localparam logic [4:0] PSS_MODE_STC = 5'h0d;

  // Reset values
  localparam logic [23:0] PSS_RST_FREQ = 24'h000000;
  localparam logic [1:0] PSS_RST_CHAN = 2'h1;
  localparam logic [5:0] PSS_RST_PINMAP = 6'h0f;
  localparam logic [11:0] PSS_RST_BITSEL = 12'h688;

  // Timing counts
  localparam logic [1:0] PSS_SETTLE = 2'h2;

  typedef struct packed {
    logic [23:0] freq;
    logic [4:0] mode;
    logic fec;
    logic rand_en;
    logic inv_en;
    logic diff_en;
  } pss_chcfg_t;

  typedef struct packed {
    logic used;
    logic [31:0] name;
    pss_chcfg_t ch1;
    pss_chcfg_t ch2;
  } pss_slot_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pss_bus_t;

  typedef enum logic [1:0] {
    PSS_ST_SAMPLE,
    PSS_ST_LOAD,
    PSS_ST_RUN
  } pss_state_t;

endpackage

// ### hw/pss_top.sv
`timescale 1ns/1ns
module pss_top
  import pss_pkg::*;
#(
  parameter int PIN_CNT = pss_pkg::PSS_PIN_CNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Preset pins, low when grounded
  input wire logic [PIN_CNT-1:0] preset_pin_n,
  // Register port
  input wire logic [pss_pkg::PSS_ADDR_W-1:0] addr,
  input wire logic [pss_pkg::PSS_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pss_pkg::PSS_DATA_W-1:0] rdata,
  // Active configuration
  output pss_pkg::pss_chcfg_t ch1_cfg,
  output pss_pkg::pss_chcfg_t ch2_cfg,
  output logic tx_enable
);
  import pss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [PIN_CNT-1:0] sync1;
    logic [PIN_CNT-1:0] sync2;
    logic [3:0] code;
    logic [1:0] sampled;
    pss_state_t st;
    pss_chcfg_t ch1;
    pss_chcfg_t ch2;
    logic [1:0] chan;
    logic [31:0] name;
    logic [3:0] rpt_slot;
    logic rpt_all;
    logic [31:0] rdata;
    logic tx_en;
    logic [5:0] pin_used;
    logic [11:0] bit_sel;
  } pss_state_s_t;

  pss_state_s_t s_r;
  pss_state_s_t s_nxt;
  pss_slot_t slots_r [PSS_SLOTS];
  logic save_we;
  logic [3:0] save_idx;
  pss_slot_t save_val;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic pss_chcfg_t apply_cmd(input pss_chcfg_t c, input logic [3:0] op,
                                           input logic [31:0] arg);
    pss_chcfg_t r;
    r = c;
    unique case (op)
      PSS_CMD_MODE: r.mode = arg[4:0];
      PSS_CMD_FEC: r.fec = arg[0];
      PSS_CMD_FREQ: r.freq = arg[23:0];
      PSS_CMD_FLAGS: begin
        r.rand_en = arg[0];
        r.inv_en = arg[1];
        r.diff_en = arg[2];
      end
      default: r = c;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] cfg_word(input pss_chcfg_t c);
    return {c.diff_en, c.inv_en, c.rand_en, c.fec, 1'b0, c.mode, c.freq[21:0]};
  endfunction

  // Build code from up to four mapped pins; bit_sel holds pin index per bit
  function automatic logic [3:0] pick_code(input logic [PIN_CNT-1:0] lvl,
                                           input logic [5:0] used, input logic [11:0] sel);
    logic [3:0] c;
    logic [2:0] p;
    c = 4'h0;
    for (int b = 0; b < PSS_CODE_W; b++) begin
      p = sel[b*3 +: 3];
      if (used[b] && int'(p) < PIN_CNT) begin
        c[b] = lvl[p];
      end
    end
    return c;
  endfunction

  logic [3:0] op;
  logic has_arg;
  pss_slot_t rd_slot;
  logic [31:0] slot_word;
  assign op = wdata[PSS_F_OP +: 4];
  assign slot_word = cfg_word(rd_slot.ch1);
  assign has_arg = wdata[PSS_F_HASARG];
  assign rd_slot = slots_r[s_r.rpt_slot];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    save_we = 1'b0;
    save_idx = 4'h0;
    save_val = '0;
    s_nxt.sync1 = ~preset_pin_n;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.rdata = '0;
    unique case (s_r.st)
      PSS_ST_SAMPLE: begin
        // Wait until both synchroniser stages hold the pin levels
        if (s_r.sampled != PSS_SETTLE) begin
          s_nxt.sampled = s_r.sampled + 2'h1;
        end else begin
          s_nxt.code = pick_code(s_r.sync2, s_r.pin_used, s_r.bit_sel);
          s_nxt.st = PSS_ST_LOAD;
        end
      end
      PSS_ST_LOAD: begin
        if (s_r.code != 4'h0 && slots_r[s_r.code].used) begin
          s_nxt.ch1 = slots_r[s_r.code].ch1;
          s_nxt.ch2 = slots_r[s_r.code].ch2;
        end
        s_nxt.st = PSS_ST_RUN;
      end
      PSS_ST_RUN: begin
        s_nxt.tx_en = 1'b1;
      end
      default: s_nxt.st = PSS_ST_SAMPLE;
    endcase
    if (wr) begin
      unique case (addr)
        PSS_A_NAME: s_nxt.name = wdata;
        PSS_A_PINMAP: begin
          s_nxt.pin_used = wdata[5:0];
          s_nxt.bit_sel = wdata[19:8];
        end
        PSS_A_CMD: begin
          unique case (op)
            PSS_CMD_SAVE: begin
              if (has_arg && wdata[11:8] != 4'h0) begin
                save_we = 1'b1;
                save_idx = wdata[11:8];
                save_val = '{used: 1'b1, name: s_r.name, ch1: s_r.ch1, ch2: s_r.ch2};
                s_nxt.name = '0;
              end else begin
                s_nxt.rpt_all = 1'b1;
              end
            end
            PSS_CMD_LIST: begin
              s_nxt.rpt_all = !has_arg;
              s_nxt.rpt_slot = wdata[11:8];
            end
            PSS_CMD_CHAN: s_nxt.chan = wdata[9:8];
            PSS_CMD_PINMAP: s_nxt.rpt_all = 1'b0;
            default: begin
              if (s_r.chan == PSS_CH_BOTH || s_r.chan[0]) begin
                s_nxt.ch1 = apply_cmd(s_r.ch1, op, {8'h00, wdata[31:8]});
              end
              if (s_r.chan == PSS_CH_BOTH || s_r.chan[1]) begin
                s_nxt.ch2 = apply_cmd(s_r.ch2, op, {8'h00, wdata[31:8]});
              end
            end
          endcase
        end
        default: s_nxt.name = s_r.name;
      endcase
    end
    if (rd) begin
      unique case (addr)
        PSS_A_NAME: s_nxt.rdata = s_r.name;
        PSS_A_STATUS: s_nxt.rdata = {4'h0, s_r.rpt_slot, 7'h00, s_r.rpt_all, 4'h0,
                                      s_r.chan, 3'h0, s_r.tx_en, 2'(s_r.st), s_r.code};
        PSS_A_CH1: s_nxt.rdata = cfg_word(s_r.ch1);
        PSS_A_CH2: s_nxt.rdata = cfg_word(s_r.ch2);
        PSS_A_RPT_CFG: begin
          if (s_r.rpt_all) begin
            for (int i = 1; i < PSS_SLOTS; i++) begin
              s_nxt.rdata[i] = slots_r[i].used;
            end
          end else begin
            s_nxt.rdata = {rd_slot.used, slot_word[30:0]};
          end
        end
        PSS_A_RPT_NAME: s_nxt.rdata = rd_slot.name;
        PSS_A_PINMAP: s_nxt.rdata = {12'h000, s_r.bit_sel, 2'h0, s_r.pin_used};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{sync1: '0, sync2: '0, code: 4'h0, sampled: 2'h0, st: PSS_ST_SAMPLE,
               ch1: '0, ch2: '0, chan: PSS_RST_CHAN, name: '0, rpt_slot: 4'h0,
               rpt_all: 1'b0, rdata: '0, tx_en: 1'b0, pin_used: PSS_RST_PINMAP,
               bit_sel: PSS_RST_BITSEL};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (save_we) begin
      slots_r[save_idx] <= save_val;
    end
  end

  assign rdata = s_r.rdata;
  assign ch1_cfg = s_r.ch1;
  assign ch2_cfg = s_r.ch2;
  assign tx_enable = s_r.tx_en;

endmodule

// ### verif/pss_switch_model.sv
`timescale 1ns/1ns
module pss_switch_model
  import pss_pkg::*;
#(
  parameter int PIN_CNT = PSS_PIN_CNT
) (
  // Code set on the switches
  input wire logic [3:0] code,
  // Pins, pulled high while open
  output logic [PIN_CNT-1:0] preset_pin_n
);
  // Closed switch grounds its pin; spare pins stay open
  assign preset_pin_n = ~{{(PIN_CNT-4){1'b0}}, code};
endmodule

// ### verif/pss_top_checker.sv
`timescale 1ns/1ns
module pss_top_checker
  import pss_pkg::*;
#(
  parameter int PIN_CNT = PSS_PIN_CNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Active configuration
  input wire pss_pkg::pss_chcfg_t ch1_cfg,
  input wire pss_pkg::pss_chcfg_t ch2_cfg,
  input wire logic tx_enable
);
  logic [3:0] cyc_r;
  logic cmd;
  assign cmd = wr && addr == PSS_A_CMD && wdata[4] && tx_enable;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cyc_r <= 4'h0;
    else if (cyc_r != 4'hf) cyc_r <= cyc_r + 4'h1;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata without read");
  a_tx_early: assert property (tx_enable |-> cyc_r >= 4'h3)
    else $error("tx before load");
  a_tx_bound: assert property (cyc_r == 4'h8 |-> tx_enable)
    else $error("tx late");
  a_tx_stays: assert property ($past(tx_enable) |-> tx_enable)
    else $error("tx dropped");
  a_cfg_hold: assert property (tx_enable && $past(tx_enable) && !$past(wr)
    |-> $stable(ch1_cfg) && $stable(ch2_cfg)) else $error("cfg moved");
  a_mode_apply: assert property (cmd && wdata[3:0] == PSS_CMD_MODE |=>
    ch1_cfg.mode == $past(wdata[12:8]) || ch2_cfg.mode == $past(wdata[12:8]))
    else $error("mode lost");
  a_fec_apply: assert property (cmd && wdata[3:0] == PSS_CMD_FEC |=>
    ch1_cfg.fec == $past(wdata[8]) || ch2_cfg.fec == $past(wdata[8])) else $error("fec lost");
  a_freq_apply: assert property (cmd && wdata[3:0] == PSS_CMD_FREQ |=>
    ch1_cfg.freq == $past(wdata[31:8]) || ch2_cfg.freq == $past(wdata[31:8]))
    else $error("freq lost");
endmodule
bind pss_top pss_top_checker #(.PIN_CNT(PIN_CNT)) u_chk (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ch1_cfg(ch1_cfg), .ch2_cfg(ch2_cfg),
  .tx_enable(tx_enable));

// ### verif/test_preset_select_and_store.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_preset_select_and_store;
  import pss_pkg::*;
  typedef struct packed {
    logic [31:0] cmd;
    pss_chcfg_t c1;
    pss_chcfg_t c2;
  } pss_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] code = 4'h0;
  logic [5:0] pins_n;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rv;
  pss_chcfg_t ch1_cfg;
  pss_chcfg_t ch2_cfg;
  logic tx_enable;
  int n_errors = 0;
  int n_checks = 0;
  pss_row_t rows [10];
  always #25 clk = ~clk;
  pss_switch_model sw (.code(code), .preset_pin_n(pins_n));
  pss_top uut (.clk(clk), .rst(rst), .preset_pin_n(pins_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ch1_cfg(ch1_cfg), .ch2_cfg(ch2_cfg), .tx_enable(tx_enable));
  task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_t(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  task automatic rst_t(input logic [3:0] c);
    code <= c;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{32'h314, 33'h0, 33'h0}, '{32'hd15, 33'hd0, 33'hd0},
      '{32'h116, 33'hd8, 33'hd8}, '{32'h518, 33'hdd, 33'hdd}, '{32'h114, 33'hdd, 33'hdd},
      '{32'h12345617, 33'h2468acdd, 33'hdd}, '{32'h214, 33'h2468acdd, 33'hdd},
      '{32'habcd17, 33'h2468acdd, 33'h1579add}, '{32'h115, 33'h2468acdd, 33'h1579a1d},
      '{32'h16, 33'h2468acdd, 33'h1579a15}};
    rst_t(4'h0);
    `CHK({tx_enable, ch1_cfg, ch2_cfg}, {1'b1, 66'h0})
    rd_t(PSS_A_STATUS);
    `CHK(rv[3:0], 4'h0)
    $display("reset test done");
    // Both channels set alike before the coded modes
    foreach (rows[i]) begin
      wr_t(PSS_A_CMD, rows[i].cmd);
      @(negedge clk);
      `CHK({ch1_cfg, ch2_cfg}, {rows[i].c1, rows[i].c2})
    end
    $display("table test done");
    // Store from code zero, then recall by pins
    wr_t(PSS_A_NAME, 32'h6c616231);
    wr_t(PSS_A_CMD, 32'h511);
    rst_t(4'h5);
    `CHK({tx_enable, ch1_cfg, ch2_cfg}, {1'b1, rows[9].c1, rows[9].c2})
    code <= 4'h0;
    repeat (8) @(posedge clk);
    rd_t(PSS_A_STATUS);
    `CHK({rv[3:0], ch1_cfg, ch2_cfg}, {4'h5, rows[9].c1, rows[9].c2})
    wr_t(PSS_A_CMD, 32'h512);
    rd_t(PSS_A_RPT_NAME);
    `CHK(rv, 32'h6c616231)
    wr_t(PSS_A_CMD, 32'h1);
    rd_t(PSS_A_RPT_CFG);
    `CHK(rv[5], 1'b1)
    wr_t(PSS_A_CMD, 32'h3);
    rd_t(PSS_A_PINMAP);
    `CHK(rv[5:0], 6'h0f)
    rd_t(8'h40);
    `CHK(rv, 32'h0)
    $display("preset test done");
    summarize();
  end
endmodule
